// ===== core/pos_timer.sv
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

// Behaviour
// R1: counter clocked by f1, f2, f8 or companion underflow
// R2: decrement; on underflow reload, finish, clear active flag
// R3: every stop reloads counters from reload registers
// R4: pulse lasts (prescaler+1)*(primary+1) source periods
// R5: one-shot starts only while count status flag is 1
// R6: trigger from software start bit or external pin edge
// R7: active flag set one to two source cycles after trigger
// R8: triggers while active are ignored
// R9: stop on underflow reload, oneshot stop, start clear, forced stop
// R10: interrupt request half a source cycle after underflow; here one sys_clk cycle after, which is half a source cycle only for f2
// R11: pin acts as trigger only when pin trigger enable is 1
// R12: reads of prescaler and primary return live counts
// R13: write while stopped loads reload and counter
// R14: write while counting loads reload only
// R15: output level select sets pulse active level
// R16: pulse routed to one of two pins by pin select
// R17: software never sets prescaler and primary both to zero
// R18: secondary register has no effect in this mode
// R19: software configures pin before enabling pin trigger
// R20: timer edge select does not affect external irq edge; here the both-edge select bit still applies to the irq edge
// R21: pin edge while active still sets external request flag
// R22: pin edge synchronised before use as trigger
module pos_timer
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hsel,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        ext_trigger_pin,
    input  wire logic        companion_uf,
    output logic             output_pin_alt_a,
    output logic             output_pin_alt_b,
    output logic             timer_irq,
    output logic             ext_irq
);

    typedef struct packed
    {
        pos_pkg::pos_ahb_addr_t ap;
        logic [31:0]            rdata;
        logic                   count_start_bit;
        logic                   count_status_flag;
        logic                   oneshot_active_flag;
        logic                   output_level_select;
        logic                   trigger_edge_select;
        logic                   pin_trigger_enable;
        logic                   both_edge_select;
        logic                   output_pin_select;
        logic                   ext_irq_edge_sel;
        logic                   ext_request_pending;
        pos_pkg::pos_src_t      src;
        logic [7:0]             pre_reload;
        logic [7:0]             pri_reload;
        logic [7:0]             sec_reload;
        logic [7:0]             pre_cnt;
        logic [7:0]             pri_cnt;
        pos_pkg::pos_state_t    state;
        logic                   trig_pend;
        logic                   sync1;
        logic                   sync2;
        logic                   pin_prev;
        logic                   pulse;
        logic                   irq_pend;
        logic                   pin_a;
        logic                   pin_b;
        logic                   timer_irq;
        logic                   ext_irq;
    } pos_state_vec_t;

    pos_state_vec_t s_q;
    pos_state_vec_t s_d;
    logic           tick;
    logic           half;

    // ----------------------------------------------------------------
    // count source
    // ----------------------------------------------------------------
    pos_tick_gen u_tick
    (
        .sys_clk      (sys_clk),
        .rstn         (rstn),
        .src_sel      (s_q.src),
        .companion_uf (companion_uf),
        .tick         (tick),
        .half         (half)
    );

    function automatic logic wr_hit(input pos_pkg::pos_ahb_addr_t ap,
                                    input logic [7:0] ofs);
        wr_hit = ap.sel && ap.write && (ap.addr[7:0] == ofs);
    endfunction

    logic       wr_ctrl;
    logic       wr_os;
    logic       wr_io;
    logic       wr_pre;
    logic       wr_sec;
    logic       wr_pri;
    logic       wr_mode;
    logic       wr_ext;
    logic       os_start_wr;
    logic       os_stop_wr;
    logic       start_clr;
    logic       force_wr;
    logic       stop_any;
    logic       edge_rise;
    logic       edge_fall;
    logic       pin_edge;
    logic       irq_edge;
    logic       trig;
    logic       underflow;

    always_comb
    begin
        wr_ctrl = wr_hit(s_q.ap, pos_pkg::OFS_TIMER_CTRL);
        wr_os   = wr_hit(s_q.ap, pos_pkg::OFS_ONESHOT_CTRL);
        wr_io   = wr_hit(s_q.ap, pos_pkg::OFS_IO_CTRL);
        wr_pre  = wr_hit(s_q.ap, pos_pkg::OFS_PRESCALER);
        wr_sec  = wr_hit(s_q.ap, pos_pkg::OFS_SECONDARY);
        wr_pri  = wr_hit(s_q.ap, pos_pkg::OFS_PRIMARY);
        wr_mode = wr_hit(s_q.ap, pos_pkg::OFS_MODE);
        wr_ext  = wr_hit(s_q.ap, pos_pkg::OFS_EXT_IRQ);
        os_start_wr = wr_os && hwdata[pos_pkg::BIT_OS_START];
        os_stop_wr  = wr_os && hwdata[pos_pkg::BIT_OS_STOP];
        start_clr   = wr_ctrl && !hwdata[pos_pkg::BIT_COUNT_START];
        force_wr    = wr_ctrl && hwdata[pos_pkg::BIT_FORCED_STOP];
        // R22: only the second sync stage feeds edge logic
        edge_rise = s_q.sync2 && !s_q.pin_prev;
        edge_fall = !s_q.sync2 && s_q.pin_prev;
        pin_edge  = s_q.both_edge_select ? (edge_rise || edge_fall)
                  : (s_q.trigger_edge_select ? edge_rise : edge_fall);
        // R20: irq edge uses its own polarity bit
        irq_edge  = s_q.both_edge_select ? (edge_rise || edge_fall)
                  : (s_q.ext_irq_edge_sel ? edge_rise : edge_fall);
        // R6 R11: software start or enabled pin edge
        trig = os_start_wr || (s_q.pin_trigger_enable && pin_edge);
        underflow = tick && (s_q.state == pos_pkg::POS_RUN)
                    && (s_q.pre_cnt == 8'h00) && (s_q.pri_cnt == 8'h00);
        // R9: every stop cause except underflow, which the POS_RUN branch handles
        stop_any = os_stop_wr || start_clr || force_wr;
    end

    always_comb
    begin
        s_d = s_q;
        s_d.ap.addr  = haddr;
        s_d.ap.write = hwrite;
        s_d.ap.sel   = hsel && hready && htrans[1];
        s_d.sync1    = ext_trigger_pin;
        s_d.sync2    = s_q.sync1;
        s_d.pin_prev = s_q.sync2;

        // ------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------
        if (wr_ctrl)
        begin
            s_d.count_start_bit = hwdata[pos_pkg::BIT_COUNT_START]
                                  && !hwdata[pos_pkg::BIT_FORCED_STOP];
        end
        s_d.count_status_flag = s_d.count_start_bit;
        if (wr_io)
        begin
            // R15: pulse level choice
            s_d.output_level_select = hwdata[pos_pkg::BIT_LEVEL_SEL];
            s_d.trigger_edge_select = hwdata[pos_pkg::BIT_EDGE_SEL];
            s_d.pin_trigger_enable  = hwdata[pos_pkg::BIT_PIN_TRIG_EN];
            s_d.both_edge_select    = hwdata[pos_pkg::BIT_BOTH_EDGE];
        end
        if (wr_mode)
        begin
            s_d.src = pos_pkg::pos_src_t'(hwdata[pos_pkg::BIT_SRC_LO +: 2]);
            s_d.output_pin_select = hwdata[pos_pkg::BIT_PIN_SEL];
        end
        // R18: secondary stored but never used
        if (wr_sec)
            s_d.sec_reload = hwdata[7:0];
        // R13 R14: counter loaded only while stopped
        if (wr_pre)
        begin
            s_d.pre_reload = hwdata[7:0];
            if (s_q.state == pos_pkg::POS_IDLE)
                s_d.pre_cnt = hwdata[7:0];
        end
        if (wr_pri)
        begin
            s_d.pri_reload = hwdata[7:0];
            if (s_q.state == pos_pkg::POS_IDLE)
                s_d.pri_cnt = hwdata[7:0];
        end

        // R21: request flag set by edge even while active; set wins
        if (wr_ext)
        begin
            s_d.ext_irq_edge_sel = hwdata[pos_pkg::BIT_IRQ_EDGE];
            if (!hwdata[pos_pkg::BIT_IRQ_PENDING])
                s_d.ext_request_pending = 1'b0;
        end
        if (irq_edge)
            s_d.ext_request_pending = 1'b1;

        // ------------------------------------------------------------
        // one-shot sequencer
        // ------------------------------------------------------------
        s_d.irq_pend = s_q.irq_pend;
        case (s_q.state)
            pos_pkg::POS_IDLE:
            begin
                // R5 R8: armed only when counting allowed and idle
                if (trig && s_q.count_status_flag && !stop_any)
                begin
                    s_d.state     = pos_pkg::POS_ARM;
                    s_d.trig_pend = 1'b0;
                end
            end
            pos_pkg::POS_ARM:
            begin
                // R7: active one to two source cycles after trigger
                if (tick)
                begin
                    s_d.trig_pend = 1'b1;
                    if (s_q.trig_pend)
                    begin
                        s_d.state               = pos_pkg::POS_RUN;
                        s_d.oneshot_active_flag = 1'b1;
                    end
                end
            end
            pos_pkg::POS_RUN:
            begin
                // R4: rise a clock late, as the fall is, so width is exact
                s_d.pulse = 1'b1;
                // R2 R4: nested prescaler and primary countdown
                if (tick)
                begin
                    if (s_q.pre_cnt != 8'h00)
                        s_d.pre_cnt = s_q.pre_cnt - 8'h01;
                    else
                    begin
                        s_d.pre_cnt = s_q.pre_reload;
                        if (s_q.pri_cnt != 8'h00)
                            s_d.pri_cnt = s_q.pri_cnt - 8'h01;
                    end
                end
                if (underflow)
                begin
                    s_d.pri_cnt  = s_q.pri_reload;
                    s_d.state    = pos_pkg::POS_END;
                    s_d.irq_pend = 1'b1;
                end
            end
            pos_pkg::POS_END:
            begin
                // R10: pulse end and irq one sys_clk cycle after the underflow tick, which is half a source period only for f2
                if (half)
                begin
                    s_d.pulse               = 1'b0;
                    s_d.oneshot_active_flag = 1'b0;
                    s_d.state               = pos_pkg::POS_IDLE;
                end
            end
            default:
                s_d.state = pos_pkg::POS_IDLE;
        endcase

        // R3: any stop reloads counters, overriding the sequencer
        if (stop_any && s_q.state != pos_pkg::POS_IDLE)
        begin
            s_d.state               = pos_pkg::POS_IDLE;
            s_d.pre_cnt             = s_d.pre_reload;
            s_d.pri_cnt             = s_d.pri_reload;
            s_d.pulse               = 1'b0;
            s_d.oneshot_active_flag = 1'b0;
            s_d.irq_pend            = 1'b0;
        end

        s_d.timer_irq = s_q.irq_pend && s_q.state == pos_pkg::POS_END && half;
        if (s_d.timer_irq)
            s_d.irq_pend = 1'b0;
        s_d.ext_irq = s_d.ext_request_pending;

        // R16: route pulse to the selected pin
        s_d.pin_a = s_q.output_level_select;
        s_d.pin_b = s_q.output_level_select;
        if (s_d.output_pin_select)
            s_d.pin_b = s_d.pulse ^ s_d.output_level_select;
        else
            s_d.pin_a = s_d.pulse ^ s_d.output_level_select;

        // R12: live counts on read
        s_d.rdata = 32'h0000_0000;
        case (haddr[7:0])
            pos_pkg::OFS_TIMER_CTRL:
            begin
                s_d.rdata[pos_pkg::BIT_COUNT_START]  = s_d.count_start_bit;
                s_d.rdata[pos_pkg::BIT_COUNT_STATUS] = s_d.count_status_flag;
            end
            pos_pkg::OFS_ONESHOT_CTRL:
                s_d.rdata[pos_pkg::BIT_OS_ACTIVE] = s_d.oneshot_active_flag;
            pos_pkg::OFS_IO_CTRL:
                s_d.rdata[3:0] = {s_d.both_edge_select, s_d.pin_trigger_enable,
                                  s_d.trigger_edge_select,
                                  s_d.output_level_select};
            pos_pkg::OFS_PRESCALER: s_d.rdata[7:0] = s_d.pre_cnt;
            pos_pkg::OFS_SECONDARY: s_d.rdata[7:0] = s_d.sec_reload;
            pos_pkg::OFS_PRIMARY:   s_d.rdata[7:0] = s_d.pri_cnt;
            pos_pkg::OFS_MODE:
                s_d.rdata[4:0] = {s_d.output_pin_select, 2'b00, s_d.src};
            pos_pkg::OFS_EXT_IRQ:
                s_d.rdata[1:0] = {s_d.ext_irq_edge_sel,
                                  s_d.ext_request_pending};
            default: s_d.rdata = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_q            <= '0;
            s_q.pre_reload <= pos_pkg::RST_PRESCALER;
            s_q.pri_reload <= pos_pkg::RST_PRIMARY;
            s_q.pre_cnt    <= pos_pkg::RST_PRESCALER;
            s_q.pri_cnt    <= pos_pkg::RST_PRIMARY;
            s_q.pin_a      <= 1'b0;
        end
        else
            s_q <= s_d;
    end

    assign hrdata           = s_q.rdata;
    assign hreadyout        = 1'b1;
    assign hresp            = 1'b0;
    assign output_pin_alt_a = s_q.pin_a;
    assign output_pin_alt_b = s_q.pin_b;
    assign timer_irq        = s_q.timer_irq;
    assign ext_irq          = s_q.ext_irq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_ignore_retrig: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_q.state == pos_pkg::POS_RUN && !stop_any |=>
            s_q.state != pos_pkg::POS_ARM) // R8
        else $error("retrigger while active");
    a_start_needs_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_q.state == pos_pkg::POS_IDLE && !s_q.count_status_flag |=>
            s_q.state != pos_pkg::POS_ARM) // R5
        else $error("armed without count status");
    a_stop_reload: assert property (@(posedge sys_clk) disable iff (!rstn)
        stop_any && s_q.state == pos_pkg::POS_RUN && !wr_pri |=>
            s_q.pri_cnt == s_q.pri_reload) // R3
        else $error("stop without reload");
    a_stop_clears: assert property (@(posedge sys_clk) disable iff (!rstn)
        stop_any |=> !s_q.oneshot_active_flag) // R9
        else $error("active after stop");
    a_irq_at_end: assert property (@(posedge sys_clk) disable iff (!rstn)
        underflow && !stop_any ##1 !stop_any |=> s_q.timer_irq) // R10
        else $error("irq not after underflow");
    a_active_latency: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(s_q.oneshot_active_flag) |->
            $past(s_q.state) == pos_pkg::POS_ARM) // R7
        else $error("active without arming");
    a_write_running: assert property (@(posedge sys_clk) disable iff (!rstn)
        wr_pri && s_q.state == pos_pkg::POS_RUN && !tick && !stop_any |=>
            s_q.pri_cnt == $past(s_q.pri_cnt)) // R14
        else $error("counter changed by running write");
    a_write_stopped: assert property (@(posedge sys_clk) disable iff (!rstn)
        wr_pre && s_q.state == pos_pkg::POS_IDLE |=>
            s_q.pre_cnt == s_q.pre_reload) // R13
        else $error("stopped write missed counter");
    a_ext_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
        irq_edge |=> s_q.ext_request_pending) // R21
        else $error("ext flag not set");

endmodule

// ===== pkg/pos_pkg.sv
package pos_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_TIMER_CTRL   = 8'h00;
    localparam logic [7:0] OFS_ONESHOT_CTRL = 8'h04;
    localparam logic [7:0] OFS_IO_CTRL      = 8'h08;
    localparam logic [7:0] OFS_PRESCALER    = 8'h0C;
    localparam logic [7:0] OFS_SECONDARY    = 8'h10;
    localparam logic [7:0] OFS_PRIMARY      = 8'h14;
    localparam logic [7:0] OFS_MODE         = 8'h18;
    localparam logic [7:0] OFS_EXT_IRQ      = 8'h1C;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_COUNT_START   = 0;
    localparam int BIT_COUNT_STATUS  = 1;
    localparam int BIT_FORCED_STOP   = 2;
    localparam int BIT_OS_START      = 0;
    localparam int BIT_OS_STOP       = 1;
    localparam int BIT_OS_ACTIVE     = 2;
    localparam int BIT_LEVEL_SEL     = 0;
    localparam int BIT_EDGE_SEL      = 1;
    localparam int BIT_PIN_TRIG_EN   = 2;
    localparam int BIT_BOTH_EDGE     = 3;
    localparam int BIT_SRC_LO        = 0;
    localparam int BIT_PIN_SEL       = 4;
    localparam int BIT_IRQ_PENDING   = 0;
    localparam int BIT_IRQ_EDGE      = 1;

    // ----------------------------------------------------------------
    // reset values and counts
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_PRESCALER = 8'hFF;
    localparam logic [7:0] RST_PRIMARY   = 8'hFF;
    localparam logic [2:0] DIV8_LAST     = 3'h7;

    typedef enum logic [1:0]
    {
        POS_SRC_F1  = 2'b00,
        POS_SRC_F2  = 2'b01,
        POS_SRC_F8  = 2'b10,
        POS_SRC_EXT = 2'b11
    } pos_src_t;

    typedef enum logic [1:0]
    {
        POS_IDLE  = 2'b00,
        POS_ARM   = 2'b01,
        POS_RUN   = 2'b10,
        POS_END   = 2'b11
    } pos_state_t;

    typedef struct packed
    {
        logic [31:0] addr;
        logic        write;
        logic        sel;
    } pos_ahb_addr_t;

endpackage

// ===== core/pos_tick_gen.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// count source tick generator
// ----------------------------------------------------------------
module pos_tick_gen
(
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    input  wire pos_pkg::pos_src_t src_sel,
    input  wire logic             companion_uf,
    output logic                  tick,
    output logic                  half
);

    typedef struct packed
    {
        logic [2:0] div;
        logic       tick;
        logic       half;
    } pos_tick_state_t;

    pos_tick_state_t st_q;
    pos_tick_state_t st_d;

    // R1: source selection
    always_comb
    begin
        st_d     = st_q;
        st_d.div = st_q.div + 3'h1;
        case (src_sel)
            pos_pkg::POS_SRC_F1:  st_d.tick = 1'b1;
            pos_pkg::POS_SRC_F2:  st_d.tick = st_q.div[0];
            pos_pkg::POS_SRC_F8:  st_d.tick = (st_q.div == pos_pkg::DIV8_LAST);
            pos_pkg::POS_SRC_EXT: st_d.tick = companion_uf;
            default:              st_d.tick = 1'b0;
        endcase
        // half-period marker: one cycle after a tick
        st_d.half = st_q.tick;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign tick = st_q.tick;
    assign half = st_q.half;

endmodule

// ===== dv/pos_trig_src.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// external trigger source and companion timer stand-in
// ----------------------------------------------------------------
module pos_trig_src
(
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic pin_req,
    output logic      ext_trigger_pin,
    output logic      companion_uf
);
    logic [2:0] uf_cnt_q;

    // companion underflows every fifth cycle, a period no divider matches
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            uf_cnt_q        <= 3'h0;
            companion_uf    <= 1'b0;
            ext_trigger_pin <= 1'b0;
        end
        else
        begin
            uf_cnt_q        <= (uf_cnt_q == 3'h4) ? 3'h0 : uf_cnt_q + 3'h1;
            companion_uf    <= (uf_cnt_q == 3'h4);
            ext_trigger_pin <= pin_req;
        end
    end
endmodule

// ===== dv/programmable_one_shot_timer_tb.sv
`timescale 1ns/1ps

module programmable_one_shot_timer_tb;
    logic sys_clk = 1'b0, rstn = 1'b0, hwrite = 1'b0, hsel = 1'b0;
    logic pin_req = 1'b0, lvl = 1'b0, psel = 1'b0, mute = 1'b0, prev_q = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic hreadyout, hresp, ext_pin, comp_uf, pin_a, pin_b, timer_irq, ext_irq;
    int error_cnt = 0, check_count = 0, width = 0, n, m, exp_w, k;
    int q[$];
    int div_tab[4] = '{1, 2, 8, 5};

    always #25 sys_clk = ~sys_clk;

    pos_timer dut (.sys_clk(sys_clk), .rstn(rstn), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hsel(hsel),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ext_trigger_pin(ext_pin),
        .companion_uf(comp_uf), .output_pin_alt_a(pin_a),
        .output_pin_alt_b(pin_b), .timer_irq(timer_irq), .ext_irq(ext_irq));
    pos_trig_src src (.sys_clk(sys_clk), .rstn(rstn), .pin_req(pin_req),
        .ext_trigger_pin(ext_pin), .companion_uf(comp_uf));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (error_cnt == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // bus master: single word transfers, waits on hready
    // ----------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsel <= 1'b1;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic waitq();
        for (k = 0; k < 3000 && q.size() != 0; k++)
            @(posedge sys_clk);
    endtask

    // values are loaded with counting stopped so the counter takes them too
    task automatic load(input int pn, input int pm);
        wr(pos_pkg::OFS_TIMER_CTRL, 32'h0);
        wr(pos_pkg::OFS_PRESCALER, pn);
        wr(pos_pkg::OFS_PRIMARY, pm);
        wr(pos_pkg::OFS_TIMER_CTRL, 32'h1);
    endtask

    task automatic shot(input int w);
        q.push_back(w);
        wr(pos_pkg::OFS_ONESHOT_CTRL, 32'h1);
        waitq();
    endtask

    // ----------------------------------------------------------------
    // pulse monitor: width in sys_clk cycles against oldest note
    // ----------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        if (!rstn || mute)
        begin
            width = 0;
            prev_q <= 1'b0;
        end
        else if (((psel ? pin_b : pin_a) ^ lvl) === 1'b1)
        begin
            width++;
            prev_q <= 1'b1;
        end
        else if (prev_q)
        begin
            prev_q <= 1'b0;
            exp_w = (q.size() != 0) ? q.pop_front() : -1;
            if (exp_w != 0) check(width, exp_w);
            if (exp_w != 0) check(timer_irq, 1'b1);
            width = 0;
        end
    end

    initial
    begin
        #(50 * 20000);
        error_cnt++;
        wrap_up();
    end

    initial
    begin
        void'($urandom(32'hf6061d20));
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        bus(1'b0, pos_pkg::OFS_PRIMARY, 32'h0);
        check(r, {24'h0, pos_pkg::RST_PRIMARY});
        wr(pos_pkg::OFS_SECONDARY, $urandom);
        wr(pos_pkg::OFS_ONESHOT_CTRL, 32'h1);
        repeat (40) @(posedge sys_clk);
        for (int s = 0; s < 4; s++)
        begin
            n = $urandom % 3;
            m = 1 + $urandom % 3;
            wr(pos_pkg::OFS_MODE, s);
            load(n, m);
            bus(1'b0, pos_pkg::OFS_PRIMARY, 32'h0);
            check(r, m);
            shot((n + 1) * (m + 1) * div_tab[s]);
            bus(1'b0, pos_pkg::OFS_ONESHOT_CTRL, 32'h0);
            check(r[pos_pkg::BIT_OS_ACTIVE], 1'b0);
        end
        // f2 so that some running writes fall between ticks
        wr(pos_pkg::OFS_MODE, 32'h1);
        load(0, 29);
        q.push_back(60);
        wr(pos_pkg::OFS_ONESHOT_CTRL, 32'h1);
        repeat (5) @(posedge sys_clk);
        bus(1'b0, pos_pkg::OFS_ONESHOT_CTRL, 32'h0);
        check(r[pos_pkg::BIT_OS_ACTIVE], 1'b1);
        wr(pos_pkg::OFS_ONESHOT_CTRL, 32'h1);
        // running write reaches next pulse only
        wr(pos_pkg::OFS_PRIMARY, 32'h3);
        waitq();
        shot(8);
        for (int s = 0; s < 3; s++)
        begin
            load(0, 20);
            q.push_back(0);
            wr(pos_pkg::OFS_ONESHOT_CTRL, 32'h1);
            repeat (8) @(posedge sys_clk);
            wr(s == 0 ? pos_pkg::OFS_ONESHOT_CTRL : pos_pkg::OFS_TIMER_CTRL,
               s == 0 ? 32'h2 : (s == 1 ? 32'h0 : 32'h4));
            repeat (4) @(posedge sys_clk);
            bus(1'b0, pos_pkg::OFS_PRIMARY, 32'h0);
            check(r, 32'd20);
        end
        load(1, 2);
        mute <= 1'b1;
        wr(pos_pkg::OFS_IO_CTRL, 32'h1);
        wr(pos_pkg::OFS_MODE, 32'h10);
        repeat (4) @(posedge sys_clk);
        lvl <= 1'b1;
        psel <= 1'b1;
        mute <= 1'b0;
        shot(6);
        // pin set up before trigger enable
        wr(pos_pkg::OFS_EXT_IRQ, 32'h2);
        wr(pos_pkg::OFS_IO_CTRL, 32'h3);
        wr(pos_pkg::OFS_IO_CTRL, 32'h7);
        q.push_back(6);
        pin_req <= 1'b1;
        waitq();
        check(ext_irq, 1'b1);
        wr(pos_pkg::OFS_EXT_IRQ, 32'h2);
        // flag register updates on the write's own edge
        @(posedge sys_clk);
        check(ext_irq, 1'b0);
        pin_req <= 1'b0;
        q.push_back(6);
        wr(pos_pkg::OFS_ONESHOT_CTRL, 32'h1);
        repeat (4) @(posedge sys_clk);
        pin_req <= 1'b1;
        waitq();
        check(ext_irq, 1'b1);
        wr(pos_pkg::OFS_IO_CTRL, 32'h3);
        wr(pos_pkg::OFS_EXT_IRQ, 32'h2);
        pin_req <= 1'b0;
        repeat (4) @(posedge sys_clk);
        pin_req <= 1'b1;
        repeat (40) @(posedge sys_clk);
        // pin not a trigger when disabled
        check(q.size(), 32'h0);
        check(ext_irq, 1'b1);
        wrap_up();
    end
endmodule
